/* File: shared/merr_pkg.sv */
// Constants for the memory error reporting block
package merr_pkg;

	// ****************************************
	// Register bus
	// ****************************************
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [15:0] OFS_FATAL_LATCH = 16'h1084;
	localparam logic [15:0] OFS_FATAL_MASK  = 16'h1088;
	localparam logic [15:0] OFS_PB_ECC      = 16'h245C;
	localparam logic [15:0] OFS_LINK_PCTL   = 16'h5BA0;
	localparam logic [15:0] OFS_QUEUE_STS   = 16'h5BA8;
	localparam logic [15:0] OFS_IRQ_STS     = 16'h5BB0;
	localparam logic [15:0] OFS_IRQ_MASK    = 16'h5BB4;

	// ****************************************
	// Fatal error latch and mask fields
	// ****************************************
	localparam int NUM_FATAL      = 4;
	localparam int FAT_LAN_BIT    = 0;
	localparam int FAT_MNG_BIT    = 1;
	localparam int FAT_LINK_BIT   = 2;
	localparam int FAT_DMA_BIT    = 3;
	localparam logic [3:0] FATAL_LATCH_RST = 4'h0;
	localparam logic [3:0] FATAL_MASK_RST  = 4'hF;

	// ****************************************
	// Packet buffer ECC status fields
	// ****************************************
	localparam int PB_ECC_EN_BIT  = 0;
	localparam int PB_CORR_BIT    = 2;
	localparam logic PB_ECC_EN_RST = 1'h1;
	localparam logic PB_CORR_RST   = 1'h0;

	// ****************************************
	// Host-link parity control fields
	// ****************************************
	localparam int NUM_QUEUE      = 4;
	localparam int GPAR_BIT       = 0;
	localparam int QEN_BASE_BIT   = 6;
	localparam int QEN_STEP       = 2;
	localparam logic GPAR_RST      = 1'h0;
	localparam logic [3:0] QEN_RST = 4'hF;

	// ****************************************
	// Queue parity status fields
	// ****************************************
	localparam int QSTS_BASE_BIT  = 3;
	localparam logic QSTS_RST      = 1'h0;

	// ****************************************
	// Interrupt status fields
	// ****************************************
	localparam int NUM_IRQ        = 3;
	localparam int IRQ_FATAL_BIT  = 0;
	localparam int IRQ_CORR_BIT   = 1;
	localparam int IRQ_QUEUE_BIT  = 2;
	localparam logic [2:0] IRQ_STS_RST  = 3'h0;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;

endpackage

/* File: verilog/merr_queue_check.sv */
// One receive completion queue parity recorder
`timescale 1ns/1ps
`default_nettype none

module merr_queue_check
	import merr_pkg::*;
(
	// Clock and resets
	input  wire logic i_clk,
	input  wire logic i_rst_n,
	input  wire logic i_sw_reset,
	// Control
	input  wire logic i_global_en,
	input  wire logic i_queue_en,
	input  wire logic i_clear,
	// Error event
	input  wire logic i_parity_err,
	// Status
	output logic      o_flag,
	output logic      o_record
);

	logic flag_r;
	logic flag_nxt;

	assign o_record = i_parity_err & i_global_en & i_queue_en;

	assign flag_nxt = i_sw_reset ? QSTS_RST :
		(o_record | (flag_r & ~i_clear));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			flag_r <= QSTS_RST;
		end else begin
			flag_r <= flag_nxt;
		end
	end

	assign o_flag = flag_r;

endmodule
`default_nettype wire

/* File: verilog/merr_top.sv */
// Memory error reporting block with register port and interrupt
//
// Functional notes
// - LAN port and management memory fatal errors latch bits 0 and 1.
// - Host-link and DMA memory fatal errors latch bits 2 and 3.
// - Latched fatal bits stay set until a read of the latch clears them.
// - A set latch bit with its mask bit set raises the cause; masks reset to one.
// - A packet buffer correctable ECC error sets bit 2 of the ECC status.
// - The correctable flag clears only when software writes a one to it.
// - With the global parity enable at zero no parity check is done.
// - The global parity enable is reset only by the LAN power-good reset.
// - Queue 0 and 1 check enables sit at bits 6 and 8, reset to one.
// - Queue 2 and 3 check enables sit at bits 10 and 12, reset to one.
// - A recorded queue parity error halts link and DMA until software reset or a one is written to its queue status bit.
// - A recorded queue parity error sets the host-link fatal bit.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module merr_top
	import merr_pkg::*;
(
	// Clock and resets
	input  wire logic                 i_clk,
	input  wire logic                 i_rst_n,
	input  wire logic                 i_lan_power_good_rst_n,
	input  wire logic                 i_sw_reset,
	// Register port
	input  wire logic [ADDR_W-1:0]    i_addr,
	input  wire logic [DATA_W-1:0]    i_wdata,
	input  wire logic                 i_wr,
	input  wire logic                 i_rd,
	output logic      [DATA_W-1:0]    o_rdata,
	// Memory error events
	input  wire logic                 i_lan_mem_err,
	input  wire logic                 i_mng_mem_err,
	input  wire logic                 i_link_mem_err,
	input  wire logic                 i_dma_mem_err,
	input  wire logic                 i_pb_corr_err,
	input  wire logic [NUM_QUEUE-1:0] i_rx_queue_parity_err,
	// Controls to memories
	output logic                      o_parity_check_enable,
	output logic      [NUM_QUEUE-1:0] o_rx_queue_check_enable,
	output logic                      o_pb_ecc_enable,
	output logic                      o_link_dma_halt,
	// Interrupts
	output logic                      o_fatal_error_interrupt_cause,
	output logic                      o_irq
);

	// ****************************************
	// Declarations
	// ****************************************
	logic [NUM_FATAL-1:0] fatal_latch_r;
	logic [NUM_FATAL-1:0] fatal_latch_nxt;
	logic [NUM_FATAL-1:0] fatal_mask_r;
	logic [NUM_FATAL-1:0] fatal_mask_nxt;
	logic [NUM_FATAL-1:0] fatal_set;
	logic                 pb_ecc_en_r;
	logic                 pb_ecc_en_nxt;
	logic                 pb_corr_r;
	logic                 pb_corr_nxt;
	logic                 gpar_r;
	logic                 gpar_nxt;
	logic [NUM_QUEUE-1:0] qen_r;
	logic [NUM_QUEUE-1:0] qen_nxt;
	logic [NUM_QUEUE-1:0] qsts;
	logic [NUM_QUEUE-1:0] qrec;
	logic [NUM_QUEUE-1:0] qclr;
	logic [NUM_IRQ-1:0]   irq_sts_r;
	logic [NUM_IRQ-1:0]   irq_sts_nxt;
	logic [NUM_IRQ-1:0]   irq_mask_r;
	logic [NUM_IRQ-1:0]   irq_mask_nxt;
	logic [NUM_IRQ-1:0]   irq_event;
	logic                 cause;
	logic                 cause_d_r;
	logic [DATA_W-1:0]    rdata_r;
	logic [DATA_W-1:0]    rdata_nxt;
	logic [DATA_W-1:0]    link_pctl_word;
	logic [DATA_W-1:0]    qsts_word;

	// ****************************************
	// Address decode
	// ****************************************
	wire sel_latch = (i_addr == OFS_FATAL_LATCH);
	wire sel_mask  = (i_addr == OFS_FATAL_MASK);
	wire sel_pb    = (i_addr == OFS_PB_ECC);
	wire sel_pctl  = (i_addr == OFS_LINK_PCTL);
	wire sel_qsts  = (i_addr == OFS_QUEUE_STS);
	wire sel_isr   = (i_addr == OFS_IRQ_STS);
	wire sel_imr   = (i_addr == OFS_IRQ_MASK);

	wire wr_mask   = i_wr & sel_mask;
	wire wr_pb     = i_wr & sel_pb;
	wire wr_pctl   = i_wr & sel_pctl;
	wire wr_qsts   = i_wr & sel_qsts;
	wire wr_isr    = i_wr & sel_isr;
	wire wr_imr    = i_wr & sel_imr;
	wire rd_latch  = i_rd & sel_latch;

	// ****************************************
	// Receive queue parity recorders
	// ****************************************
	genvar q;
	generate
		for (q = 0; q < NUM_QUEUE; q = q + 1) begin : g_queue
			assign qclr[q] = wr_qsts & i_wdata[QSTS_BASE_BIT+q];
			merr_queue_check u_check (
				.i_clk        (i_clk),
				.i_rst_n      (i_rst_n),
				.i_sw_reset   (i_sw_reset),
				.i_global_en  (gpar_r),
				.i_queue_en   (qen_r[q]),
				.i_clear      (qclr[q]),
				.i_parity_err (i_rx_queue_parity_err[q]),
				.o_flag       (qsts[q]),
				.o_record     (qrec[q])
			);
			assign qen_nxt[q] = wr_pctl ?
				i_wdata[QEN_BASE_BIT+QEN_STEP*q] : qen_r[q];
		end
	endgenerate

	// ****************************************
	// Fatal error latch
	// ****************************************
	// events only when parity enabled
	assign fatal_set[FAT_LAN_BIT]  = i_lan_mem_err & gpar_r;
	assign fatal_set[FAT_MNG_BIT]  = i_mng_mem_err & gpar_r;
	assign fatal_set[FAT_LINK_BIT] = (i_link_mem_err & gpar_r) | (|qrec);
	assign fatal_set[FAT_DMA_BIT]  = i_dma_mem_err & gpar_r;

	assign fatal_latch_nxt = fatal_set |
		(fatal_latch_r & {NUM_FATAL{~rd_latch}});

	assign fatal_mask_nxt = wr_mask ? i_wdata[NUM_FATAL-1:0] : fatal_mask_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fatal_latch_r <= FATAL_LATCH_RST;
			fatal_mask_r  <= FATAL_MASK_RST;
		end else begin
			fatal_latch_r <= fatal_latch_nxt;
			fatal_mask_r  <= fatal_mask_nxt;
		end
	end

	assign cause = |(fatal_latch_r & fatal_mask_r);
	assign o_fatal_error_interrupt_cause = cause;

	// ****************************************
	// Packet buffer ECC status
	// ****************************************
	assign pb_ecc_en_nxt = wr_pb ? i_wdata[PB_ECC_EN_BIT] : pb_ecc_en_r;

	assign pb_corr_nxt = i_pb_corr_err |
		(pb_corr_r & ~(wr_pb & i_wdata[PB_CORR_BIT]));

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pb_ecc_en_r <= PB_ECC_EN_RST;
			pb_corr_r   <= PB_CORR_RST;
		end else begin
			pb_ecc_en_r <= pb_ecc_en_nxt;
			pb_corr_r   <= pb_corr_nxt;
		end
	end

	assign o_pb_ecc_enable = pb_ecc_en_r;

	// ****************************************
	// Host-link parity control
	// ****************************************
	assign gpar_nxt = wr_pctl ? i_wdata[GPAR_BIT] : gpar_r;

	always_ff @(posedge i_clk or negedge i_lan_power_good_rst_n) begin
		if (!i_lan_power_good_rst_n) begin
			gpar_r <= GPAR_RST;
		end else begin
			gpar_r <= gpar_nxt;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			qen_r <= QEN_RST;
		end else begin
			qen_r <= qen_nxt;
		end
	end

	assign o_parity_check_enable   = gpar_r;
	assign o_rx_queue_check_enable = qen_r & {NUM_QUEUE{gpar_r}};

	// halt while any queue error held
	assign o_link_dma_halt = |qsts;

	// ****************************************
	// Interrupt status and mask
	// ****************************************
	assign irq_event[IRQ_FATAL_BIT] = cause & ~cause_d_r;
	assign irq_event[IRQ_CORR_BIT]  = i_pb_corr_err;
	assign irq_event[IRQ_QUEUE_BIT] = |qrec;

	assign irq_sts_nxt = irq_event |
		(irq_sts_r & ~({NUM_IRQ{wr_isr}} & i_wdata[NUM_IRQ-1:0]));
	assign irq_mask_nxt = wr_imr ? i_wdata[NUM_IRQ-1:0] : irq_mask_r;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_sts_r  <= IRQ_STS_RST;
			irq_mask_r <= IRQ_MASK_RST;
			cause_d_r  <= 1'h0;
		end else begin
			irq_sts_r  <= irq_sts_nxt;
			irq_mask_r <= irq_mask_nxt;
			cause_d_r  <= cause;
		end
	end

	assign o_irq = |(irq_sts_r & irq_mask_r);

	// ****************************************
	// Read data
	// ****************************************
	// reserved bits read as zero
	always_comb begin
		link_pctl_word           = '0;
		link_pctl_word[GPAR_BIT] = gpar_r;
		for (int i = 0; i < NUM_QUEUE; i++) begin
			link_pctl_word[QEN_BASE_BIT+QEN_STEP*i] = qen_r[i];
		end
	end

	always_comb begin
		qsts_word = '0;
		qsts_word[QSTS_BASE_BIT +: NUM_QUEUE] = qsts;
	end

	always_comb begin
		rdata_nxt = '0;
		if (i_rd) begin
			if (sel_latch) begin
				rdata_nxt[NUM_FATAL-1:0] = fatal_latch_r;
			end else if (sel_mask) begin
				rdata_nxt[NUM_FATAL-1:0] = fatal_mask_r;
			end else if (sel_pb) begin
				rdata_nxt[PB_ECC_EN_BIT] = pb_ecc_en_r;
				rdata_nxt[PB_CORR_BIT]   = pb_corr_r;
			end else if (sel_pctl) begin
				rdata_nxt = link_pctl_word;
			end else if (sel_qsts) begin
				rdata_nxt = qsts_word;
			end else if (sel_isr) begin
				rdata_nxt[NUM_IRQ-1:0] = irq_sts_r;
			end else if (sel_imr) begin
				rdata_nxt[NUM_IRQ-1:0] = irq_mask_r;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign o_rdata = rdata_r;

endmodule
`default_nettype wire

/* File: sim/merr_top_props.sv */
// Checker for the memory error reporting block
`timescale 1ns/1ps
`default_nettype none

module merr_top_props
	import merr_pkg::*;
(
	// Clock and reset
	input wire logic                 i_clk,
	input wire logic                 i_rst_n,
	input wire logic                 i_sw_reset,
	// Register port
	input wire logic [ADDR_W-1:0]    i_addr,
	input wire logic                 i_wr,
	input wire logic                 i_rd,
	input wire logic [DATA_W-1:0]    o_rdata,
	// Events
	input wire logic                 i_lan_mem_err,
	input wire logic                 i_mng_mem_err,
	input wire logic                 i_link_mem_err,
	input wire logic                 i_dma_mem_err,
	input wire logic                 i_pb_corr_err,
	input wire logic [NUM_QUEUE-1:0] i_rx_queue_parity_err,
	// Controls and cause
	input wire logic                 o_parity_check_enable,
	input wire logic [NUM_QUEUE-1:0] o_rx_queue_check_enable,
	input wire logic                 o_link_dma_halt,
	input wire logic                 o_fatal_error_interrupt_cause
);
	// ****************************************
	// Helpers
	// ****************************************
	wire logic       q_hit;
	wire logic       ev_any;
	wire logic [6:0] q_spread;
	assign q_hit = |(i_rx_queue_parity_err & o_rx_queue_check_enable);
	assign ev_any = i_lan_mem_err | i_mng_mem_err | i_link_mem_err
		| i_dma_mem_err | q_hit;
	assign q_spread = {o_rx_queue_check_enable[3], 1'b0,
		o_rx_queue_check_enable[2], 1'b0, o_rx_queue_check_enable[1],
		1'b0, o_rx_queue_check_enable[0]};

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	sequence rd_at(logic [15:0] a);
		i_rd && i_addr == a;
	endsequence

	// ****************************************
	// Properties
	// ****************************************
	gpar_gates_q_a: assert property (!o_parity_check_enable |-> o_rx_queue_check_enable == 4'h0) else $error("queue check without global");
	gpar_no_event_a: assert property (!o_parity_check_enable && !o_fatal_error_interrupt_cause && !i_wr |=> !o_fatal_error_interrupt_cause) else $error("event seen with parity off");
	read_clears_a: assert property (rd_at(OFS_FATAL_LATCH) ##0 !ev_any |=> !o_fatal_error_interrupt_cause) else $error("cause kept after read");
	cause_hold_a: assert property (o_fatal_error_interrupt_cause && !i_rd && !i_wr |=> o_fatal_error_interrupt_cause) else $error("cause dropped");
	halt_set_a: assert property (q_hit && !i_sw_reset |=> o_link_dma_halt) else $error("no halt on queue error");
	halt_hold_a: assert property (o_link_dma_halt && !i_sw_reset && !i_wr |=> o_link_dma_halt) else $error("halt dropped");
	sw_clear_a: assert property (i_sw_reset |=> !o_link_dma_halt) else $error("halt kept after reset");
	halt_idle_a: assert property (!o_link_dma_halt && !q_hit |=> !o_link_dma_halt) else $error("halt without cause");
	pb_flag_a: assert property (i_pb_corr_err ##1 rd_at(OFS_PB_ECC) |=> o_rdata[2]) else $error("corrected flag missing");
	pctl_read_a: assert property (rd_at(OFS_LINK_PCTL) ##0 o_parity_check_enable |=> o_rdata == {19'h0, $past(q_spread), 6'h01}) else $error("control read wrong");
	latch_rsvd_a: assert property (rd_at(OFS_FATAL_LATCH) |=> o_rdata[31:4] == 28'h0) else $error("reserved bits set");
endmodule

bind merr_top merr_top_props u_props (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sw_reset(i_sw_reset),
	.i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_lan_mem_err(i_lan_mem_err), .i_mng_mem_err(i_mng_mem_err),
	.i_link_mem_err(i_link_mem_err), .i_dma_mem_err(i_dma_mem_err),
	.i_pb_corr_err(i_pb_corr_err),
	.i_rx_queue_parity_err(i_rx_queue_parity_err),
	.o_parity_check_enable(o_parity_check_enable),
	.o_rx_queue_check_enable(o_rx_queue_check_enable),
	.o_link_dma_halt(o_link_dma_halt),
	.o_fatal_error_interrupt_cause(o_fatal_error_interrupt_cause));
`default_nettype wire

/* File: sim/tb.sv */
// Self-checking testbench for the memory error reporting block
`timescale 1ns/1ps
`default_nettype none

module tb
	import merr_pkg::*;
;
	typedef struct packed {
		logic [15:0] a;
		logic        w;
		logic [31:0] d;
		logic [31:0] e;
	} merr_row_t;

	logic        i_clk, i_rst_n, pg_rst_n, sw_rst, wr, rd, pb_err;
	logic        pchk, ecc_en, halt, cause, irq;
	logic [15:0] addr;
	logic [31:0] wdata, rdata;
	logic [3:0]  ev, qerr, qen;
	int          bad_count = 0;
	int          checks = 0;
	merr_row_t   rows [10] = '{
		'{OFS_FATAL_LATCH, 1'b0, 32'h0, 32'h0},
		'{OFS_FATAL_MASK, 1'b0, 32'h0, 32'hF},
		'{OFS_PB_ECC, 1'b0, 32'h0, 32'h1},
		'{OFS_LINK_PCTL, 1'b0, 32'h0, 32'h1540},
		'{OFS_IRQ_MASK, 1'b0, 32'h0, 32'h0},
		'{OFS_FATAL_MASK, 1'b1, 32'hF, 32'hF},
		'{16'h0000, 1'b1, 32'hFFFFFFFF, 32'h0},
		'{OFS_PB_ECC, 1'b1, 32'h0, 32'h0},
		'{OFS_PB_ECC, 1'b1, 32'h1, 32'h1},
		'{OFS_LINK_PCTL, 1'b1, 32'h1541, 32'h1541}};

	merr_top u_dut (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_lan_power_good_rst_n(pg_rst_n),
		.i_sw_reset(sw_rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
		.i_rd(rd), .o_rdata(rdata), .i_lan_mem_err(ev[0]),
		.i_mng_mem_err(ev[1]), .i_link_mem_err(ev[2]), .i_dma_mem_err(ev[3]),
		.i_pb_corr_err(pb_err), .i_rx_queue_parity_err(qerr),
		.o_parity_check_enable(pchk), .o_rx_queue_check_enable(qen),
		.o_pb_ecc_enable(ecc_en), .o_link_dma_halt(halt),
		.o_fatal_error_interrupt_cause(cause), .o_irq(irq));

	// ****************************************
	// Tasks
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge i_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge i_clk);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [15:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask

	task automatic pulse(input logic [3:0] e, input logic [3:0] q,
		input logic p);
		@(posedge i_clk);
		ev <= e;
		qerr <= q;
		pb_err <= p;
		@(posedge i_clk);
		ev <= 4'h0;
		qerr <= 4'h0;
		pb_err <= 1'b0;
		#1;
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ****************************************
	// Clock and watchdog
	// ****************************************
	initial begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		i_rst_n = 1'b0;
		pg_rst_n = 1'b0;
		{sw_rst, wr, rd, pb_err} = 4'h0;
		{ev, qerr, addr, wdata} = 56'h0;
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		pg_rst_n <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr_reg(rows[i].a, rows[i].d);
			end
			rd_reg(rows[i].a, rows[i].e);
		end
		for (int k = 0; k < 4; k++) begin
			pulse(4'h1 << k, 4'h0, 1'b0);
			chk(32'(cause), 32'h1);
			rd_reg(OFS_FATAL_LATCH, 32'h1 << k);
			rd_reg(OFS_FATAL_LATCH, 32'h0);
		end
		wr_reg(OFS_FATAL_MASK, 32'h0);
		pulse(4'h1, 4'h0, 1'b0);
		chk(32'(cause), 32'h0);
		wr_reg(OFS_FATAL_MASK, 32'hF);
		chk(32'(cause), 32'h1);
		rd_reg(OFS_FATAL_LATCH, 32'h1);
		wr_reg(OFS_LINK_PCTL, 32'h1540);
		chk(32'({pchk, qen}), 32'h0);
		pulse(4'hF, 4'hF, 1'b0);
		rd_reg(OFS_FATAL_LATCH, 32'h0);
		chk(32'(halt), 32'h0);
		@(posedge i_clk);
		pb_err <= 1'b1;
		@(posedge i_clk);
		pb_err <= 1'b0;
		addr <= OFS_PB_ECC;
		rd <= 1'b1;
		@(posedge i_clk);
		rd <= 1'b0;
		#1;
		chk(rdata, 32'h5);
		wr_reg(OFS_PB_ECC, 32'h1);
		rd_reg(OFS_PB_ECC, 32'h5);
		wr_reg(OFS_PB_ECC, 32'h5);
		rd_reg(OFS_PB_ECC, 32'h1);
		chk(32'(ecc_en), 32'h1);
		wr_reg(OFS_PB_ECC, 32'h0);
		chk(32'(ecc_en), 32'h0);
		wr_reg(OFS_LINK_PCTL, 32'h0101);
		chk(32'(qen), 32'h2);
		pulse(4'h0, 4'h1, 1'b0);
		chk(32'(halt), 32'h0);
		pulse(4'h0, 4'h2, 1'b0);
		chk(32'(halt), 32'h1);
		rd_reg(OFS_QUEUE_STS, 32'h10);
		rd_reg(OFS_FATAL_LATCH, 32'h4);
		@(posedge i_clk);
		sw_rst <= 1'b1;
		@(posedge i_clk);
		sw_rst <= 1'b0;
		#1;
		chk(32'(halt), 32'h0);
		pulse(4'h0, 4'h2, 1'b0);
		chk(32'(halt), 32'h1);
		wr_reg(OFS_QUEUE_STS, 32'h10);
		chk(32'(halt), 32'h0);
		rd_reg(OFS_FATAL_LATCH, 32'h4);
		chk(32'(irq), 32'h0);
		wr_reg(OFS_IRQ_MASK, 32'h7);
		chk(32'(irq), 32'h1);
		rd_reg(OFS_IRQ_STS, 32'h7);
		wr_reg(OFS_IRQ_STS, 32'h7);
		chk(32'(irq), 32'h0);
		@(posedge i_clk);
		i_rst_n <= 1'b0;
		@(posedge i_clk);
		i_rst_n <= 1'b1;
		rd_reg(OFS_LINK_PCTL, 32'h1541);
		chk(32'(ecc_en), 32'h1);
		@(posedge i_clk);
		pg_rst_n <= 1'b0;
		@(posedge i_clk);
		pg_rst_n <= 1'b1;
		rd_reg(OFS_LINK_PCTL, 32'h1540);
		report_and_stop();
	end
endmodule
`default_nettype wire
